// file: hw/ccm_pkg.sv
// ccm_pkg: constants shared by the contact input run/stop monitor.
// assumes a 20 MHz system clock and a word-wide plain register port.
package ccm_pkg;

    // time base
    localparam int CCM_CLK_HZ        = 20_000_000;
    localparam int CCM_TICK_S        = 1;
    localparam int CCM_CYC_PER_TICK  = CCM_TICK_S * CCM_CLK_HZ;

    // register addresses (word index on the plain port)
    localparam logic [3:0] CCM_A_IN_CFG    = 4'h0;
    localparam logic [3:0] CCM_A_ALM_ACT   = 4'h1;
    localparam logic [3:0] CCM_A_IN1_DLY   = 4'h2;
    localparam logic [3:0] CCM_A_IN1_OFF   = 4'h3;
    localparam logic [3:0] CCM_A_IN2_DLY   = 4'h4;
    localparam logic [3:0] CCM_A_IN2_OFF   = 4'h5;
    localparam logic [3:0] CCM_A_COMM_WAIT = 4'h6;
    localparam logic [3:0] CCM_A_OUT_CFG   = 4'h7;
    localparam logic [3:0] CCM_A_STATUS    = 4'h8;

    // input config fields: inputs 1 and 2 {type[1:0], edge_form, nc}; input 3 nc only
    localparam int CCM_F_IN1 = 0;
    localparam int CCM_F_IN2 = 4;
    localparam int CCM_F_IN3_NC = 8;
    localparam int CCM_F_NC   = 0;
    localparam int CCM_F_EDGE = 1;
    localparam int CCM_F_TYPE = 2;

    // signal types
    localparam logic [1:0] CCM_TYPE_OFF     = 2'h0;
    localparam logic [1:0] CCM_TYPE_EXTSW   = 2'h1;
    localparam logic [1:0] CCM_TYPE_RUNSTOP = 2'h2;
    localparam logic [1:0] CCM_TYPE_SPLIT   = 2'h3;

    // alarm actions, fields {comm[5:4], in2[3:2], in1[1:0]}
    localparam logic [1:0] CCM_ACT_OFF  = 2'h0;
    localparam logic [1:0] CCM_ACT_CONT = 2'h1;
    localparam logic [1:0] CCM_ACT_STOP = 2'h2;

    // output config: polarity [5:0], type of outputs 4..6 at [7:6].. [11:10]
    localparam int CCM_F_OTYPE = 6;
    localparam logic [1:0] CCM_OT_OFF   = 2'h0;
    localparam logic [1:0] CCM_OT_RUN   = 2'h1;
    localparam logic [1:0] CCM_OT_FAULT = 2'h2;
    localparam logic [1:0] CCM_OT_WARN  = 2'h3;

    // status bits; alarm bits clear on write of one
    localparam int CCM_S_RUN  = 0;
    localparam int CCM_S_AL1  = 1;
    localparam int CCM_S_AL2  = 2;
    localparam int CCM_S_COMM = 3;
    localparam int CCM_S_IN3  = 4;

    // ranges and reset values
    localparam int CCM_DLY_W  = 9;
    localparam int CCM_OFF_W  = 4;
    localparam int CCM_WAIT_W = 10;
    localparam logic [8:0] CCM_DLY_MAX  = 9'h12C;
    localparam logic [3:0] CCM_OFF_MAX  = 4'hA;
    localparam logic [9:0] CCM_WAIT_MIN = 10'h01E;
    localparam logic [9:0] CCM_WAIT_MAX = 10'h258;
    localparam logic [8:0] CCM_RST_IN_CFG  = 9'h048;
    localparam logic [5:0] CCM_RST_ALM_ACT = 6'h1A;

endpackage : ccm_pkg

// file: hw/ccm_ext_monitor.sv
// ccm_ext_monitor: start delay and off-detection filter for one
// external-switch contact input. assumes a one-cycle second tick.
`timescale 1ns/10ps
`default_nettype none
module ccm_ext_monitor
    import ccm_pkg::*;
(
    // clock and reset
    input  wire logic                 i_clk,
    input  wire logic                 i_reset_n,
    // control
    input  wire logic                 i_enable,
    input  wire logic                 i_running,
    input  wire logic                 i_tick,
    input  wire logic [CCM_DLY_W-1:0] i_delay,
    input  wire logic [CCM_OFF_W-1:0] i_off_time,
    input  wire logic                 i_asserted,
    // result
    output logic                      o_detect
);
    logic [CCM_DLY_W-1:0] dly_cnt_r, dly_cnt_nxt;
    logic [CCM_OFF_W-1:0] off_cnt_r, off_cnt_nxt;
    logic                 fired_r, fired_nxt;
    logic                 detect_nxt;
    logic                 armed;

    always_comb begin
        // zero delay means watched at all times, stopped or not
        armed = i_enable &&
                ((i_delay == '0) || (i_running && dly_cnt_r >= i_delay)); // [RULE_07] [RULE_10] [RULE_11]
        dly_cnt_nxt = dly_cnt_r;
        if (!i_running) begin
            dly_cnt_nxt = '0;
        end else if (i_tick && dly_cnt_r < i_delay) begin
            dly_cnt_nxt = dly_cnt_r + 1'b1; // [RULE_19]
        end
        off_cnt_nxt = off_cnt_r;
        if (!armed || i_asserted) begin
            off_cnt_nxt = '0;
        end else if (i_tick && off_cnt_r < i_off_time) begin
            off_cnt_nxt = off_cnt_r + 1'b1; // [RULE_08]
        end
        detect_nxt = armed && !i_asserted && !fired_r &&
                     (off_cnt_r >= i_off_time); // [RULE_08]
        fired_nxt = fired_r;
        if (!armed || i_asserted) begin
            fired_nxt = 1'b0;
        end else if (detect_nxt) begin
            fired_nxt = 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            dly_cnt_r <= '0;
            off_cnt_r <= '0;
            fired_r   <= 1'b0;
            o_detect  <= 1'b0;
        end else begin
            dly_cnt_r <= dly_cnt_nxt;
            off_cnt_r <= off_cnt_nxt;
            fired_r   <= fired_nxt;
            o_detect  <= detect_nxt;
        end
    end

    quiet_unarmed_a: assert property (@(posedge i_clk) // [RULE_10]
        disable iff (!i_reset_n) !armed |=> !o_detect)
        else $error("detect raised while not armed");

    off_filter_a: assert property (@(posedge i_clk) // [RULE_08]
        disable iff (!i_reset_n) o_detect |-> !$past(i_asserted) &&
                     $past(off_cnt_r) >= $past(i_off_time))
        else $error("detect before off time elapsed");

    start_delay_a: assert property (@(posedge i_clk) // [RULE_07]
        disable iff (!i_reset_n)
        (i_delay != '0 && $rose(i_running)) |-> !o_detect [*2])
        else $error("detect inside start delay");

endmodule : ccm_ext_monitor
`default_nettype wire

// file: hw/ccm_run_monitor.sv
// ccm_run_monitor: contact input run/stop decoding, external-switch
// alarms, communication-error watchdog and contact outputs 1 to 6.
// assumes contact inputs synchronous to i_clk, 1 = contact closed.
//
// Overview of operation
// (RULE_01) level run/stop: run while input asserted
// (RULE_02) edge run/stop: each rise toggles operation
// (RULE_03) input 3 always edge form
// (RULE_04) split: input 1 runs, input 2 stops
// (RULE_05) split: both asserted means stopped
// (RULE_06) split: stop released, run held restarts
// (RULE_07) external switch watched after start delay
// (RULE_08) off only after off time, then alarm
// (RULE_09) separate alarms for inputs 1 and 2
// (RULE_10) no alarm after stop by run/stop input
// (RULE_11) delay 0 continuous, 1..300 during run
// (RULE_12) alarm action continue or stop operation
// (RULE_13) comm alarm action, wait 30..600 s default 30
// (RULE_14) input alarm default stop, delay/off ranges
// (RULE_15) outputs 1..3 fixed, polarity only
// (RULE_16) six outputs; only 4..6 retypeable
// (RULE_17) inputs normally open or normally closed
// (RULE_18) inputs 1,2 level or edge form; the input 2 edge form bit is never read
// (RULE_19) disabled alarm never raised; 1 s base
// (RULE_20) partner holds level inputs one tick
`timescale 1ns/10ps
`default_nettype none
module ccm_run_monitor
    import ccm_pkg::*;
#(
    parameter int P_CYC_PER_TICK = CCM_CYC_PER_TICK
)(
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_reset_n,
    // register port
    input  wire logic [3:0]  i_addr,
    input  wire logic [31:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [31:0] o_rdata,
    // contacts
    input  wire logic [2:0]  i_contact_in,
    input  wire logic        i_comm_ok,
    output logic      [5:0]  o_contact_out,
    output logic             o_running,
    output logic             o_mode_request
);
    typedef enum logic {CCM_STOPPED, CCM_RUNNING} ccm_run_e;

    function automatic logic [CCM_WAIT_W-1:0] clip(
        input logic [31:0] v, input logic [31:0] lo, input logic [31:0] hi);
        logic [31:0] r;
        r = (v < lo) ? lo : ((v > hi) ? hi : v);
        return r[CCM_WAIT_W-1:0];
    endfunction : clip

    // registers
    logic [8:0]            in_cfg_r, in_cfg_nxt;
    logic [5:0]            act_r, act_nxt;
    logic [CCM_DLY_W-1:0]  dly1_r, dly1_nxt, dly2_r, dly2_nxt;
    logic [CCM_OFF_W-1:0]  off1_r, off1_nxt, off2_r, off2_nxt;
    logic [CCM_WAIT_W-1:0] wait_r, wait_nxt;
    logic [11:0]           out_cfg_r, out_cfg_nxt;
    logic [2:0]            alm_r, alm_nxt;
    logic [31:0]           rdata_nxt;
    // run state and timing
    ccm_run_e              run_r, run_nxt;
    logic [31:0]           tb_cnt_r, tb_cnt_nxt;
    logic                  tick_r, tick_nxt;
    logic [CCM_WAIT_W-1:0] comm_cnt_r, comm_cnt_nxt;
    logic [2:0]            asr_prev_r;
    logic [5:0]            out_nxt;
    logic                  mode_req_nxt;
    // decode
    logic [2:0]            asr;
    logic [2:0]            rise;
    logic [1:0]            type1, type2, act1, act2, actc;
    logic                  det1, det2, comm_set;
    logic                  fault, warn;

    always_comb begin
        asr[0] = i_contact_in[0] ^ in_cfg_r[CCM_F_IN1 + CCM_F_NC]; // [RULE_17]
        asr[1] = i_contact_in[1] ^ in_cfg_r[CCM_F_IN2 + CCM_F_NC]; // [RULE_17]
        asr[2] = i_contact_in[2] ^ in_cfg_r[CCM_F_IN3_NC]; // [RULE_17]
        rise   = asr & ~asr_prev_r;
        type1  = in_cfg_r[CCM_F_IN1 + CCM_F_TYPE +: 2];
        type2  = in_cfg_r[CCM_F_IN2 + CCM_F_TYPE +: 2];
        act1   = act_r[1:0];
        act2   = act_r[3:2];
        actc   = act_r[5:4];
        fault  = (alm_r[0] && act1 == CCM_ACT_STOP) ||
                 (alm_r[1] && act2 == CCM_ACT_STOP) ||
                 (alm_r[2] && actc == CCM_ACT_STOP); // [RULE_12]
        warn   = (alm_r[0] && act1 == CCM_ACT_CONT) ||
                 (alm_r[1] && act2 == CCM_ACT_CONT) ||
                 (alm_r[2] && actc == CCM_ACT_CONT); // [RULE_12]
    end

    // one-second time base
    always_comb begin
        tick_nxt   = (tb_cnt_r == 32'(P_CYC_PER_TICK - 1)); // [RULE_19]
        tb_cnt_nxt = tick_nxt ? '0 : tb_cnt_r + 1'b1;
    end

    // run/stop decoding
    always_comb begin
        run_nxt = run_r;
        if (type1 == CCM_TYPE_SPLIT) begin
            // stop wins; releasing stop with run held restarts
            run_nxt = (asr[0] && !asr[1]) ? CCM_RUNNING : CCM_STOPPED; // [RULE_04] [RULE_05] [RULE_06]
        end else if (type1 == CCM_TYPE_RUNSTOP) begin
            if (!in_cfg_r[CCM_F_IN1 + CCM_F_EDGE]) begin
                run_nxt = asr[0] ? CCM_RUNNING : CCM_STOPPED; // [RULE_01] [RULE_18]
            end else if (rise[0]) begin
                run_nxt = (run_r == CCM_RUNNING) ? CCM_STOPPED
                                                 : CCM_RUNNING; // [RULE_02] [RULE_18]
            end
        end else begin
            run_nxt = CCM_STOPPED;
        end
        // a stop-action alarm holds the chiller off until cleared
        if (fault) begin
            run_nxt = CCM_STOPPED; // [RULE_12]
        end
        mode_req_nxt = rise[2]; // [RULE_03]
    end

    // external switch monitors; each reads the asserted level, whatever the edge form bit
    ccm_ext_monitor u_mon1 (
        .i_clk      (i_clk),
        .i_reset_n  (i_reset_n),
        .i_enable   (type1 == CCM_TYPE_EXTSW && act1 != CCM_ACT_OFF),
        .i_running  (run_r == CCM_RUNNING),
        .i_tick     (tick_r),
        .i_delay    (dly1_r),
        .i_off_time (off1_r),
        .i_asserted (asr[0]),
        .o_detect   (det1)
    );

    ccm_ext_monitor u_mon2 (
        .i_clk      (i_clk),
        .i_reset_n  (i_reset_n),
        .i_enable   (type2 == CCM_TYPE_EXTSW && act2 != CCM_ACT_OFF &&
                     type1 != CCM_TYPE_SPLIT),
        .i_running  (run_r == CCM_RUNNING),
        .i_tick     (tick_r),
        .i_delay    (dly2_r),
        .i_off_time (off2_r),
        .i_asserted (asr[1]),
        .o_detect   (det2)
    );

    // communication watchdog, counted in seconds since last good frame
    always_comb begin
        comm_cnt_nxt = comm_cnt_r;
        if (i_comm_ok) begin
            comm_cnt_nxt = '0;
        end else if (tick_r && comm_cnt_r < wait_r) begin
            comm_cnt_nxt = comm_cnt_r + 1'b1;
        end
        comm_set = actc != CCM_ACT_OFF && !i_comm_ok &&
                   tick_r && comm_cnt_r == wait_r - 1'b1; // [RULE_13] [RULE_19]
    end

    // register file
    always_comb begin
        in_cfg_nxt  = in_cfg_r;
        act_nxt     = act_r;
        dly1_nxt    = dly1_r;
        off1_nxt    = off1_r;
        dly2_nxt    = dly2_r;
        off2_nxt    = off2_r;
        wait_nxt    = wait_r;
        out_cfg_nxt = out_cfg_r;
        alm_nxt     = alm_r;
        rdata_nxt   = '0;
        if (i_wr) begin
            case (i_addr)
                CCM_A_IN_CFG:    in_cfg_nxt  = i_wdata[8:0];
                CCM_A_ALM_ACT:   act_nxt     = i_wdata[5:0];
                CCM_A_IN1_DLY:   dly1_nxt    = CCM_DLY_W'(clip(i_wdata, 0, 300)); // [RULE_14]
                CCM_A_IN1_OFF:   off1_nxt    = CCM_OFF_W'(clip(i_wdata, 0, 10)); // [RULE_14]
                CCM_A_IN2_DLY:   dly2_nxt    = CCM_DLY_W'(clip(i_wdata, 0, 300)); // [RULE_14]
                CCM_A_IN2_OFF:   off2_nxt    = CCM_OFF_W'(clip(i_wdata, 0, 10)); // [RULE_14]
                CCM_A_COMM_WAIT: wait_nxt    = clip(i_wdata, 30, 600); // [RULE_13]
                CCM_A_OUT_CFG:   out_cfg_nxt = i_wdata[11:0];
                CCM_A_STATUS:    alm_nxt     = alm_r & ~i_wdata[3:1];
                default:         alm_nxt     = alm_r;
            endcase
        end
        // a new detection wins over a clear in the same cycle
        // a detect still in flight when the action turns off is dropped
        if (det1 && act1 != CCM_ACT_OFF) alm_nxt[0] = 1'b1; // [RULE_09]
        if (det2 && act2 != CCM_ACT_OFF) alm_nxt[1] = 1'b1; // [RULE_09]
        if (comm_set) alm_nxt[2] = 1'b1; // [RULE_13]
        if (i_rd) begin
            case (i_addr)
                CCM_A_IN_CFG:    rdata_nxt = 32'(in_cfg_r);
                CCM_A_ALM_ACT:   rdata_nxt = 32'(act_r);
                CCM_A_IN1_DLY:   rdata_nxt = 32'(dly1_r);
                CCM_A_IN1_OFF:   rdata_nxt = 32'(off1_r);
                CCM_A_IN2_DLY:   rdata_nxt = 32'(dly2_r);
                CCM_A_IN2_OFF:   rdata_nxt = 32'(off2_r);
                CCM_A_COMM_WAIT: rdata_nxt = 32'(wait_r);
                CCM_A_OUT_CFG:   rdata_nxt = 32'(out_cfg_r);
                CCM_A_STATUS:    rdata_nxt = 32'({asr[2], alm_r,
                                                  run_r == CCM_RUNNING});
                default:         rdata_nxt = '0;
            endcase
        end
    end

    // contact outputs: 1..3 fixed meaning, 4..6 selectable
    always_comb begin
        out_nxt[0] = (run_nxt == CCM_RUNNING); // [RULE_15]
        out_nxt[1] = fault; // [RULE_15]
        out_nxt[2] = warn; // [RULE_15]
        for (int k = 0; k < 3; k++) begin
            case (out_cfg_nxt[CCM_F_OTYPE + 2*k +: 2])
                CCM_OT_RUN:   out_nxt[3+k] = (run_nxt == CCM_RUNNING); // [RULE_16]
                CCM_OT_FAULT: out_nxt[3+k] = fault;
                CCM_OT_WARN:  out_nxt[3+k] = warn;
                default:      out_nxt[3+k] = 1'b0;
            endcase
        end
        // new config applies at once so polarity never lags the state
        out_nxt = out_nxt ^ out_cfg_nxt[5:0];
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            in_cfg_r       <= CCM_RST_IN_CFG;
            act_r          <= CCM_RST_ALM_ACT;
            dly1_r         <= '0;
            off1_r         <= '0;
            dly2_r         <= '0;
            off2_r         <= '0;
            wait_r         <= CCM_WAIT_MIN;
            out_cfg_r      <= '0;
            alm_r          <= '0;
            o_rdata        <= '0;
            run_r          <= CCM_STOPPED;
            tb_cnt_r       <= '0;
            tick_r         <= 1'b0;
            comm_cnt_r     <= '0;
            asr_prev_r     <= '0;
            o_contact_out  <= '0;
            o_running      <= 1'b0;
            o_mode_request <= 1'b0;
        end else begin
            in_cfg_r       <= in_cfg_nxt;
            act_r          <= act_nxt;
            dly1_r         <= dly1_nxt;
            off1_r         <= off1_nxt;
            dly2_r         <= dly2_nxt;
            off2_r         <= off2_nxt;
            wait_r         <= wait_nxt;
            out_cfg_r      <= out_cfg_nxt;
            alm_r          <= alm_nxt;
            o_rdata        <= rdata_nxt;
            run_r          <= run_nxt;
            tb_cnt_r       <= tb_cnt_nxt;
            tick_r         <= tick_nxt;
            comm_cnt_r     <= comm_cnt_nxt;
            asr_prev_r     <= asr;
            o_contact_out  <= out_nxt;
            o_running      <= (run_nxt == CCM_RUNNING);
            o_mode_request <= mode_req_nxt;
        end
    end

    sequence both_held_s;
        type1 == CCM_TYPE_SPLIT && asr[0] && asr[1];
    endsequence

    split_stop_wins_a: assert property (@(posedge i_clk) // [RULE_05]
        disable iff (!i_reset_n)
        both_held_s |=> !o_running)
        else $error("ran with stop and run both held");

    level_follows_a: assert property (@(posedge i_clk) // [RULE_01]
        disable iff (!i_reset_n)
        (type1 == CCM_TYPE_RUNSTOP && !in_cfg_r[CCM_F_IN1 + CCM_F_EDGE]
         && !fault) |=> (o_running == $past(asr[0])))
        else $error("run state not following level input");

    edge_toggles_a: assert property (@(posedge i_clk) // [RULE_02]
        disable iff (!i_reset_n)
        (type1 == CCM_TYPE_RUNSTOP && in_cfg_r[CCM_F_IN1 + CCM_F_EDGE]
         && rise[0] && !fault) |=> (o_running != $past(o_running)))
        else $error("edge did not toggle operation");

    split_restart_a: assert property (@(posedge i_clk) // [RULE_06]
        disable iff (!i_reset_n)
        (type1 == CCM_TYPE_SPLIT && asr[0] && $fell(asr[1]) && !fault)
        |=> o_running)
        else $error("no restart after stop released");

    in3_pulse_a: assert property (@(posedge i_clk) // [RULE_03]
        disable iff (!i_reset_n)
        o_mode_request |-> $past(asr[2]) && !$past(asr_prev_r[2]) ##1
                           !o_mode_request)
        else $error("mode request not a single edge pulse");

    disabled_quiet_a: assert property (@(posedge i_clk) // [RULE_19]
        disable iff (!i_reset_n)
        (act1 == CCM_ACT_OFF && !alm_r[0]) |=> !alm_r[0])
        else $error("disabled alarm raised");

    quiet_in2_a: assert property (@(posedge i_clk) // [RULE_19]
        disable iff (!i_reset_n)
        (act2 == CCM_ACT_OFF && !alm_r[1]) |=> !alm_r[1])
        else $error("disabled input 2 alarm raised");

    fault_stops_a: assert property (@(posedge i_clk) // [RULE_12]
        disable iff (!i_reset_n)
        fault |=> !o_running && o_contact_out[1] != out_cfg_r[1])
        else $error("stop action did not stop operation");

    tick_spacing_a: assert property (@(posedge i_clk) // [RULE_19]
        disable iff (!i_reset_n)
        tick_r |=> !tick_r)
        else $error("time base ticks back to back");

    run_out_a: assert property (@(posedge i_clk) // [RULE_15]
        disable iff (!i_reset_n)
        o_contact_out[0] == (o_running ^ out_cfg_r[0]))
        else $error("run contact disagrees with run state");

endmodule : ccm_run_monitor
`default_nettype wire

// file: verif/ccm_contact_partner.sv
// ccm_contact_partner: customer switches and controller at the contacts.
// assumes the bench hands over logical contact levels and polarity.
`timescale 1ns/10ps
`default_nettype none
module ccm_contact_partner #(
    parameter int P_COMM_GAP = 40
)(
    // clock
    input  wire logic       i_clk,
    // commands from the bench
    input  wire logic [2:0] i_asserted,
    input  wire logic [2:0] i_nc,
    input  wire logic       i_comm_en,
    // wires to the device
    output logic      [2:0] o_contact,
    output logic            o_comm_ok
);
    int gap_cnt = 0;
    // a normally-closed switch opens when asserted
    assign o_contact = i_asserted ^ i_nc;
    always @(posedge i_clk) begin
        gap_cnt <= (gap_cnt >= P_COMM_GAP) ? 0 : gap_cnt + 1;
        o_comm_ok <= i_comm_en && (gap_cnt == P_COMM_GAP);
    end
endmodule : ccm_contact_partner
`default_nettype wire

// file: verif/ccm_run_monitor_bench.sv
// ccm_run_monitor_bench: self-checking bench for the run/stop monitor.
// assumes a 10-cycle tick so that second-based counts stay short.
`timescale 1ns/10ps
`default_nettype none
module ccm_run_monitor_bench;
    import ccm_pkg::*;
    localparam int TICK = 10;
    localparam int HOLD = 12;
    logic        i_clk = 1'b0;
    logic        i_reset_n = 1'b0;
    logic        i_wr = 1'b0;
    logic        i_rd = 1'b0;
    logic [3:0]  i_addr = 4'h0;
    logic [31:0] i_wdata = 32'h0;
    logic [31:0] rdata;
    logic [31:0] rd_v;
    logic [2:0]  asserted = 3'h2;
    logic [2:0]  nc = 3'h0;
    logic [2:0]  contact;
    logic        comm_en = 1'b1;
    logic        comm_ok;
    logic        running;
    logic        mode_req;
    logic [5:0]  c_out;
    logic [13:0] sq = 14'b11_10_11_01_00_10_11;
    logic [3:0]  ra [8] = '{CCM_A_IN_CFG, CCM_A_ALM_ACT, CCM_A_IN1_DLY,
        CCM_A_IN2_OFF, CCM_A_COMM_WAIT, CCM_A_OUT_CFG, CCM_A_STATUS, 4'hF};
    logic [31:0] rv [8] = '{32'h48, 32'h1A, 32'h0, 32'h0, 32'h1E, 32'h0,
        32'h0, 32'h0};
    int n_errors = 0;
    int cmp_count = 0;
    int mode = 0;
    int exp_run = 0;
    int opol = 0;
    int force_stop = 0;
    int n_pulse;
    int k;
    int seed = 32'h3c114314;

    ccm_run_monitor #(.P_CYC_PER_TICK(TICK)) i_ccm_run_monitor (
        .i_clk(i_clk), .i_reset_n(i_reset_n), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(rdata),
        .i_contact_in(contact), .i_comm_ok(comm_ok), .o_contact_out(c_out),
        .o_running(running), .o_mode_request(mode_req));
    ccm_contact_partner i_ccm_contact_partner (
        .i_clk(i_clk), .i_asserted(asserted), .i_nc(nc),
        .i_comm_en(comm_en), .o_contact(contact), .o_comm_ok(comm_ok));

    initial begin
        forever #25 i_clk = ~i_clk;
    end

    task automatic tally_and_finish;
        if (n_errors == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : tally_and_finish

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 rd_v = rdata;
    endtask : rd

    // polls a status bit; running out of polls ends the run
    task automatic wait_bit(input int b, input int lim, output int n);
        n = 0;
        rd(CCM_A_STATUS);
        while (rd_v[b] !== 1'b1 && n < lim) begin
            rd(CCM_A_STATUS);
            n += 2;
        end
        if (rd_v[b] !== 1'b1) begin
            n_errors++;
            tally_and_finish();
        end
    endtask : wait_bit

    // drives contact levels and steps the reference model
    task automatic apply(input logic a1, input logic a2, input logic a3);
        logic p1;
        logic p3;
        p1 = asserted[0];
        p3 = asserted[2];
        @(posedge i_clk);
        asserted <= {a3, a2, a1};
        if (mode == 0) exp_run = a1;
        else if (mode == 1) exp_run = (a1 && !p1) ? !exp_run : exp_run;
        else exp_run = a1 && !a2;
        if (force_stop != 0) exp_run = 0;
        n_pulse = 0;
        // each level stays longer than one tick
        repeat (HOLD) begin
            @(posedge i_clk);
            #1 n_pulse += mode_req;
        end
        chk(running, exp_run);
        chk(c_out[0], exp_run ^ opol);
        chk(n_pulse, a3 && !p3);
    endtask : apply

    initial begin
        repeat (12) @(posedge i_clk);
        i_reset_n <= 1'b1;
        for (k = 0; k < 8; k++) begin
            rd(ra[k]);
            chk(rd_v, rv[k]);
        end
        wr(CCM_A_IN2_DLY, 301 + ($random(seed) & 32'hFF));
        rd(CCM_A_IN2_DLY);
        chk(rd_v, 32'h12C);
        wr(CCM_A_COMM_WAIT, 32'h5);
        rd(CCM_A_COMM_WAIT);
        chk(rd_v, 32'h1E);
        wr(CCM_A_COMM_WAIT, 32'h2BC);
        rd(CCM_A_COMM_WAIT);
        chk(rd_v, 32'h258);
        wr(CCM_A_COMM_WAIT, 32'h1E);
        wr(CCM_A_IN2_DLY, 32'h0);
        for (k = 0; k < 2; k++) begin
            wr(CCM_A_IN_CFG, k ? 32'h49 : 32'h48);
            nc[0] <= k[0];
            apply(1, 1, k[0]);
            apply(0, 1, 0);
        end
        wr(CCM_A_IN_CFG, 32'h48);
        nc[0] <= 1'b0;
        wr(CCM_A_OUT_CFG, 32'h1);
        opol = 1;
        apply(1, 1, 0);
        apply(0, 1, 0);
        wr(CCM_A_OUT_CFG, 32'h0);
        opol = 0;
        mode = 1;
        wr(CCM_A_IN_CFG, 32'h4A);
        for (k = 0; k < 4; k++) apply(!k[0], 1, 0);
        mode = 2;
        wr(CCM_A_IN_CFG, 32'h4C);
        for (k = 0; k < 7; k++) apply(sq[13-2*k], sq[12-2*k], 0);
        mode = 0;
        wr(CCM_A_IN_CFG, 32'h48);
        apply(1, 1, 0);
        force_stop = 1;
        apply(1, 0, 0);
        rd(CCM_A_STATUS);
        chk(rd_v[2:0], 3'b100);
        chk(c_out[1], 1'b1);
        apply(0, 1, 0);
        wr(CCM_A_STATUS, 32'h4);
        force_stop = 0;
        rd(CCM_A_STATUS);
        chk(rd_v[2:0], 3'b000);
        wr(CCM_A_ALM_ACT, 32'h16);
        wr(CCM_A_OUT_CFG, 32'hE40);
        apply(1, 1, 0);
        apply(1, 0, 0);
        rd(CCM_A_STATUS);
        chk(rd_v[2:0], 3'b101);
        chk(c_out[2], 1'b1);
        chk(c_out[5:3], 3'b101);
        apply(0, 1, 0);
        wr(CCM_A_STATUS, 32'h4);
        wr(CCM_A_ALM_ACT, 32'h12);
        apply(1, 0, 0);
        repeat (2 * TICK) @(posedge i_clk);
        rd(CCM_A_STATUS);
        chk(rd_v[2:0], 3'b001);
        apply(0, 1, 0);
        wr(CCM_A_ALM_ACT, 32'h1A);
        wr(CCM_A_IN2_OFF, 32'h3);
        apply(1, 1, 0);
        @(posedge i_clk);
        asserted <= 3'b001;
        repeat (15) @(posedge i_clk);
        rd(CCM_A_STATUS);
        chk(rd_v[2], 1'b0);
        wait_bit(2, 60, k);
        force_stop = 1;
        apply(0, 1, 0);
        wr(CCM_A_STATUS, 32'h4);
        force_stop = 0;
        wr(CCM_A_IN2_OFF, 32'h0);
        apply(0, 0, 0);
        wait_bit(2, 20, k);
        apply(0, 1, 0);
        wr(CCM_A_STATUS, 32'h4);
        wr(CCM_A_IN2_DLY, 32'h2);
        asserted <= 3'b001;
        repeat (4) @(posedge i_clk);
        rd(CCM_A_STATUS);
        chk(rd_v[2:0], 3'b001);
        wait_bit(2, 80, k);
        force_stop = 1;
        apply(0, 1, 0);
        wr(CCM_A_STATUS, 32'h4);
        force_stop = 0;
        apply(1, 1, 0);
        apply(0, 1, 0);
        apply(0, 0, 0);
        repeat (4 * TICK) @(posedge i_clk);
        rd(CCM_A_STATUS);
        chk(rd_v[2], 1'b0);
        apply(0, 1, 0);
        @(posedge i_clk);
        comm_en <= 1'b0;
        wait_bit(3, 800, k);
        chk(k > 240, 1'b1);
        chk(c_out[2], 1'b1);
        @(posedge i_clk);
        comm_en <= 1'b1;
        wr(CCM_A_STATUS, 32'h8);
        rd(CCM_A_STATUS);
        chk(rd_v[3], 1'b0);
        tally_and_finish();
    end
endmodule : ccm_run_monitor_bench
`default_nettype wire
